//--- core/ssp_regs.vh
// Constants for the synchronous SRAM port control block
`ifndef SSP_REGS_VH
`define SSP_REGS_VH
`define SSP_ADDR_W 20
`define SSP_DATA_W 32
`define SSP_LANES 4
`define SSP_SYNC_STAGES 3
`define SSP_ORDER_RST 1'b1
`define SSP_OE_N_RST 1'b1
`define SSP_OP_IDLE 2'h0
`define SSP_OP_READ 2'h1
`define SSP_OP_WRITE 2'h2
`define SSP_BURST_START 2'h0
`define SSP_BURST_STEP 2'h1
`endif

//--- core/ssp_buf2.v
// Two-entry buffer with registered outputs and honest back-pressure
`timescale 1ns/1ps
module ssp_buf2 #(
    parameter W = 8
) (
    input wire clk_i,
    input wire rst_n_i,
    input wire en_i,
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [W-1:0] in_data_i,
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [W-1:0] out_data_o
);
    reg main_valid_q;
    reg skid_valid_q;
    reg in_ready_q;
    reg [W-1:0] main_q;
    reg [W-1:0] skid_q;
    wire push = in_valid_i & ~skid_valid_q;
    wire pop = main_valid_q & out_ready_i;

    // Ready mirrors an empty skid slot in its own flop, so no gate sits on the port
    assign in_ready_o = in_ready_q;
    assign out_valid_o = main_valid_q;
    assign out_data_o = main_q;

    // Main slot feeds the output, skid slot catches a word while output stalls
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            main_valid_q <= 1'b0;
            skid_valid_q <= 1'b0;
            in_ready_q <= 1'b1;
            main_q <= {W{1'b0}};
            skid_q <= {W{1'b0}};
        end else if (en_i) begin
            if (!main_valid_q || pop) begin
                if (skid_valid_q) begin
                    main_q <= skid_q;
                    main_valid_q <= 1'b1;
                    skid_valid_q <= push;
                    in_ready_q <= ~push;
                    skid_q <= in_data_i;
                end else begin
                    main_q <= in_data_i;
                    main_valid_q <= push;
                end
            end else if (push) begin
                skid_q <= in_data_i;
                skid_valid_q <= 1'b1;
                in_ready_q <= 1'b0;
            end
        end
    end
endmodule

//--- core/ssp_port.v
// Host-facing port control of a pipelined burst SRAM
//
// Summary of operation
// - First select is active low, sampled per edge
// - Second select is active high, sampled per edge
// - Third select is active low, sampled per edge
// - Output enable low drives, high floats data
// - Float on write data, emergence, deselect
// - Edge ignored while clock qualifier high
// - Qualifier high holds state, no deselect
// - Input data captured on rising edge
// - Read data from previous edge's address
// - Parity lanes follow data, own byte select
// - Strap high interleaved, low linear order
// - Unconnected strap defaults high, interleaved
// - Access starts only with all selects active
// - Bursts step two low bits, wrap four
// - Deselect floats outputs after next edge
`timescale 1ns/1ps
`include "ssp_regs.vh"
module ssp_port (
    input wire clk_i,
    input wire rst_n_i,
    input wire clock_qualify_n_i,
    input wire select_low_first_n_i,
    input wire select_high_i,
    input wire select_low_second_n_i,
    input wire write_n_i,
    input wire advance_or_load_i,
    input wire [`SSP_ADDR_W-1:0] addr_i,
    input wire [`SSP_LANES-1:0] byte_write_select_n_i,
    input wire output_enable_n_i,
    input wire burst_order_strap_i,
    input wire [`SSP_DATA_W-1:0] byte_data_lanes_i,
    output wire [`SSP_DATA_W-1:0] byte_data_lanes_o,
    output wire byte_data_lanes_oe_o,
    input wire [`SSP_LANES-1:0] byte_parity_lanes_i,
    output wire [`SSP_LANES-1:0] byte_parity_lanes_o,
    output wire byte_parity_lanes_oe_o,
    output wire [`SSP_ADDR_W-1:0] core_rd_addr_o,
    input wire [`SSP_DATA_W-1:0] core_rd_data_i,
    input wire [`SSP_LANES-1:0] core_rd_par_i,
    output wire core_wr_valid_o,
    input wire core_wr_ready_i,
    output wire [`SSP_ADDR_W-1:0] core_wr_addr_o,
    output wire [`SSP_LANES-1:0] core_wr_mask_o,
    output wire [`SSP_DATA_W-1:0] core_wr_data_o,
    output wire [`SSP_LANES-1:0] core_wr_par_o,
    output wire wr_buf_ready_o,
    output wire burst_order_o
);
    localparam BUF_W = `SSP_ADDR_W + 2 * `SSP_LANES + `SSP_DATA_W;

    // Qualifier low recognises the edge; the access pipeline and write buffer hang off this
    wire ce = ~clock_qualify_n_i;
    // All three selects must be at their active levels together
    wire sel = ~select_low_first_n_i & select_high_i & ~select_low_second_n_i;

    // Stage one holds the access taken at the last qualified edge: its kind,
    // its burst base and count, and the address the core is looking at.
    // Stage two marks the edge whose data pins carry the write word, so the
    // write data arrives two qualified edges after its address.
    // Read data is registered once more on its way out, which is where the
    // single cycle of read latency comes from.
    reg [1:0] op1_q;
    reg [1:0] op_d;
    reg [`SSP_ADDR_W-1:0] base_q;
    reg [`SSP_ADDR_W-1:0] base_d;
    reg [1:0] cnt_q;
    reg [1:0] cnt_d;
    reg [1:0] low_d;
    reg [`SSP_ADDR_W-1:0] addr1_q;
    reg [`SSP_LANES-1:0] bw1_q;
    reg wr2_q;
    reg [`SSP_ADDR_W-1:0] addr2_q;
    reg [`SSP_LANES-1:0] bw2_q;
    reg rd_phase_q;
    reg rd_phase_d;
    reg [`SSP_DATA_W-1:0] dout_q;
    reg [`SSP_LANES-1:0] pout_q;
    reg lanes_oe_q;
    reg [`SSP_SYNC_STAGES-1:0] oe_sync_q;
    reg oe_n_q;
    reg [`SSP_SYNC_STAGES-1:0] strap_sync_q;
    reg strap_q;
    reg order_q;

    // Async pins: three flops, a change counts once stages two and three agree.
    // The strap chain keeps shifting in reset, because the burst order is
    // taken there; resetting it would pin the order to its default for good.
    // The enable chain restarts from the floating level, so the lanes stay
    // quiet for a few cycles after reset until the pin has been seen twice.
    always @(posedge clk_i) begin
        strap_sync_q <= {strap_sync_q[1:0], burst_order_strap_i};
        if (!rst_n_i) begin
            oe_sync_q <= {`SSP_SYNC_STAGES{`SSP_OE_N_RST}};
            oe_n_q <= `SSP_OE_N_RST;
            // Until the chain agrees the strap reads high, as a floating pin does
            if (strap_sync_q[1] == strap_sync_q[2]) begin
                strap_q <= strap_sync_q[2];
            end else begin
                strap_q <= `SSP_ORDER_RST;
            end
        end else begin
            oe_sync_q <= {oe_sync_q[1:0], output_enable_n_i};
            if (oe_sync_q[1] == oe_sync_q[2]) begin
                oe_n_q <= oe_sync_q[2];
            end
            if (strap_sync_q[1] == strap_sync_q[2]) begin
                strap_q <= strap_sync_q[2];
            end
        end
    end

    // Strap is caught while reset is held; a change in operation is ignored
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            order_q <= strap_q;
        end
    end

    // Load or advance decision and the burst address of this edge
    always @* begin
        op_d = op1_q;
        base_d = base_q;
        cnt_d = cnt_q;
        if (!advance_or_load_i) begin
            base_d = addr_i;
            cnt_d = `SSP_BURST_START;
            if (sel) begin
                op_d = write_n_i ? `SSP_OP_READ : `SSP_OP_WRITE;
            end else begin
                op_d = `SSP_OP_IDLE;
            end
        end else if (op1_q != `SSP_OP_IDLE) begin
            cnt_d = cnt_q + `SSP_BURST_STEP;
        end
        // Only the two low bits move; two-bit count wraps after four
        if (order_q) begin
            low_d = base_d[1:0] ^ cnt_d;
        end else begin
            low_d = base_d[1:0] + cnt_d;
        end
        rd_phase_d = (op1_q == `SSP_OP_READ);
    end

    // Access pipeline; a held qualifier freezes it without deselecting
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            op1_q <= `SSP_OP_IDLE;
            base_q <= {`SSP_ADDR_W{1'b0}};
            cnt_q <= `SSP_BURST_START;
            addr1_q <= {`SSP_ADDR_W{1'b0}};
            bw1_q <= {`SSP_LANES{1'b1}};
            wr2_q <= 1'b0;
            addr2_q <= {`SSP_ADDR_W{1'b0}};
            bw2_q <= {`SSP_LANES{1'b1}};
            rd_phase_q <= 1'b0;
            dout_q <= {`SSP_DATA_W{1'b0}};
            pout_q <= {`SSP_LANES{1'b0}};
        end else if (ce) begin
            op1_q <= op_d;
            base_q <= base_d;
            cnt_q <= cnt_d;
            addr1_q <= {base_d[`SSP_ADDR_W-1:2], low_d};
            bw1_q <= byte_write_select_n_i;
            wr2_q <= (op1_q == `SSP_OP_WRITE);
            addr2_q <= addr1_q;
            bw2_q <= bw1_q;
            // Read data latched one edge after its address was taken
            rd_phase_q <= rd_phase_d;
            if (rd_phase_d) begin
                dout_q <= core_rd_data_i;
                pout_q <= core_rd_par_i;
            end
        end
    end

    // Drive only in a read data phase with output enable low; deselect, write
    // data phase and the clock after leaving deselect never have rd_phase set.
    // Updated even when the edge is masked, since output enable is not clocked.
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            lanes_oe_q <= 1'b0;
        end else begin
            lanes_oe_q <= (ce ? rd_phase_d : rd_phase_q) & ~oe_n_q;
        end
    end

    // Write data sampled from the pins at the data-phase edge
    wire push = ce & wr2_q;
    wire [BUF_W-1:0] push_word = {addr2_q, ~bw2_q, byte_data_lanes_i, byte_parity_lanes_i};
    wire [BUF_W-1:0] pop_word;

    // A stalled core would otherwise lose a write, as the port cannot wait
    ssp_buf2 #(
        .W(BUF_W)
    ) u_wbuf (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .en_i(ce),
        .in_valid_i(push),
        .in_ready_o(wr_buf_ready_o),
        .in_data_i(push_word),
        .out_valid_o(core_wr_valid_o),
        .out_ready_i(core_wr_ready_i),
        .out_data_o(pop_word)
    );

    assign core_wr_addr_o = pop_word[BUF_W-1 -: `SSP_ADDR_W];
    assign core_wr_mask_o = pop_word[`SSP_DATA_W + 2*`SSP_LANES - 1 -: `SSP_LANES];
    assign core_wr_data_o = pop_word[`SSP_DATA_W + `SSP_LANES - 1 -: `SSP_DATA_W];
    assign core_wr_par_o = pop_word[`SSP_LANES-1:0];
    assign core_rd_addr_o = addr1_q;
    assign byte_data_lanes_o = dout_q;
    assign byte_parity_lanes_o = pout_q;
    assign byte_data_lanes_oe_o = lanes_oe_q;
    assign byte_parity_lanes_oe_o = lanes_oe_q;
    assign burst_order_o = order_q;
endmodule

//--- sim/ssp_port_chk.sv
// Assertion checker for the SRAM port control block
`timescale 1ns/1ps
`include "ssp_regs.vh"
module ssp_port_chk (
    input wire clk_i, rst_n_i, clock_qualify_n_i, select_low_first_n_i, select_high_i, select_low_second_n_i,
    input wire write_n_i, advance_or_load_i, output_enable_n_i, wr_buf_ready_o, core_wr_valid_o, burst_order_o,
    input wire byte_data_lanes_oe_o, byte_parity_lanes_oe_o,
    input wire [`SSP_ADDR_W-1:0] addr_i, core_rd_addr_o,
    input wire [`SSP_DATA_W-1:0] byte_data_lanes_o, core_rd_data_i,
    input wire [`SSP_LANES-1:0] byte_parity_lanes_o, core_rd_par_i
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Qualified edge, full selection and the kinds of load
    wire q = !clock_qualify_n_i;
    wire sel = !select_low_first_n_i && select_high_i && !select_low_second_n_i;
    wire ld = q && !advance_or_load_i;
    wire rd = ld && sel && write_n_i;
    wire wr = ld && sel && !write_n_i;
    wire oe = byte_data_lanes_oe_o;
    chk_rd_addr: assert property (rd |=> core_rd_addr_o == $past(addr_i)) else $error("read address lost");
    chk_rd_data: assert property ((!output_enable_n_i)[*5] ##0 rd ##1 (q && !output_enable_n_i) |=> oe &&
        byte_data_lanes_o == $past(core_rd_data_i) && byte_parity_lanes_o == $past(core_rd_par_i))
        else $error("read data wrong");
    chk_desel_float: assert property (ld && !sel ##1 q |=> !oe) else $error("drives after deselect");
    chk_write_float: assert property (wr ##1 q |=> !oe) else $error("drives in write data");
    chk_pin_float: assert property ((output_enable_n_i)[*5] |=> !oe) else $error("drives with enable high");
    chk_par_oe: assert property (oe == byte_parity_lanes_oe_o) else $error("parity drive differs");
    chk_freeze: assert property (!q |=> $stable(core_rd_addr_o) && $stable(core_wr_valid_o) &&
        $stable(byte_data_lanes_o)) else $error("state moved while frozen");
    chk_wr_push: assert property (wr ##1 q ##1 (q && wr_buf_ready_o) |=> core_wr_valid_o)
        else $error("write word not pushed");
    chk_burst_step: assert property (rd ##1 (q && advance_or_load_i) |=> core_rd_addr_o[19:2] == $past(core_rd_addr_o[19:2])
        && core_rd_addr_o[1:0] == (burst_order_o ? $past(core_rd_addr_o[1:0]) ^ 2'h1 : $past(core_rd_addr_o[1:0]) + 2'h1))
        else $error("burst step wrong");
endmodule

//--- sim/ssp_core_model.sv
// Behavioural memory core behind the port, with a stallable write side
`timescale 1ns/1ps
module ssp_core_model (
    input wire clk_i,
    input wire clock_qualify_n_i,
    input wire stall_i,
    input wire [19:0] rd_addr_i,
    output wire [31:0] rd_data_o,
    output wire [3:0] rd_par_o,
    input wire wr_valid_i,
    output wire wr_ready_o,
    input wire [19:0] wr_addr_i,
    input wire [3:0] wr_mask_i,
    input wire [31:0] wr_data_i,
    input wire [3:0] wr_par_i
);
    logic [31:0] mem [16];
    logic [3:0] par [16];
    // Small array aliased on the low address bits keeps the model short
    assign rd_data_o = mem[rd_addr_i[3:0]];
    assign rd_par_o = par[rd_addr_i[3:0]];
    assign wr_ready_o = !stall_i;
    initial begin
        for (int i = 0; i < 16; i++) begin
            mem[i] = 32'h01010101 * i;
            par[i] = i[3:0];
        end
    end
    // Lane-wise write, only on a qualified edge with a taken word
    always @(posedge clk_i) begin
        if (!clock_qualify_n_i && wr_valid_i && wr_ready_o) begin
            for (int k = 0; k < 4; k++) begin
                if (wr_mask_i[k]) begin
                    mem[wr_addr_i[3:0]][8*k+:8] <= wr_data_i[8*k+:8];
                    par[wr_addr_i[3:0]][k] <= wr_par_i[k];
                end
            end
        end
    end
endmodule

//--- sim/testbench.sv
// Self-checking bench for the SRAM port control block
`timescale 1ns/1ps
`include "ssp_regs.vh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; $display("Error %0t %h %h", $time, g, e); end end
module testbench;
    logic clk_i = 0, rst_n_i = 0, cq = 0, s1 = 0, s2 = 1, s3 = 0, we_n = 1, adv = 0, oe_n = 0, strap = 1, stall = 0;
    logic [19:0] addr = 0, ra, wa;
    logic [3:0] bw_n = 0, pin_p = 0, dp, wm, wp, rp;
    logic [31:0] din = 0, nd = 0, dout, rd, wd;
    logic oe, poe, wv, wrdy, brdy, ord;
    int num_errors = 0, n_checks = 0, cycles = 0;
    ssp_port ssp_port_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .clock_qualify_n_i(cq), .select_low_first_n_i(s1),
        .select_high_i(s2), .select_low_second_n_i(s3), .write_n_i(we_n), .advance_or_load_i(adv), .addr_i(addr),
        .byte_write_select_n_i(bw_n), .output_enable_n_i(oe_n), .burst_order_strap_i(strap), .byte_data_lanes_i(din),
        .byte_data_lanes_o(dout), .byte_data_lanes_oe_o(oe), .byte_parity_lanes_i(pin_p), .byte_parity_lanes_o(dp),
        .byte_parity_lanes_oe_o(poe), .core_rd_addr_o(ra), .core_rd_data_i(rd), .core_rd_par_i(rp),
        .core_wr_valid_o(wv), .core_wr_ready_i(wrdy), .core_wr_addr_o(wa), .core_wr_mask_o(wm),
        .core_wr_data_o(wd), .core_wr_par_o(wp), .wr_buf_ready_o(brdy), .burst_order_o(ord));
    ssp_core_model ssp_core_model_inst (.clk_i(clk_i), .clock_qualify_n_i(cq), .stall_i(stall), .rd_addr_i(ra),
        .rd_data_o(rd), .rd_par_o(rp), .wr_valid_i(wv), .wr_ready_o(wrdy), .wr_addr_i(wa), .wr_mask_i(wm),
        .wr_data_i(wd), .wr_par_i(wp));
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    // Hang guard, well above the hundred or so cycles the tests need
    always @(posedge clk_i) begin
        cycles++;
        if (cycles > 3000) begin
            num_errors++;
            close_out;
        end
    end
    // One edge of pin activity, driven at the falling edge
    task op(input logic c, l, w, input logic [2:0] ds, input logic [19:0] a);
        @(negedge clk_i);
        cq = c; adv = !l; we_n = !w; s1 = ds[0]; s2 = !ds[1]; s3 = ds[2]; addr = a; din = nd;
        @(posedge clk_i);
        #1;
    endtask
    task do_reset(input logic st);
        @(negedge clk_i);
        rst_n_i = 0;
        strap = st;
        repeat (8) @(negedge clk_i);
        rst_n_i = 1;
        // Output enable passes three flops after reset before the lanes may drive
        repeat (4) @(negedge clk_i);
    endtask
    function automatic logic [31:0] pat(input logic [3:0] i);
        return 32'h01010101 * i;
    endfunction
    task t_read;
        op(0, 1, 0, 0, 20'h5);
        `CHK(ra, 20'h5)
        op(0, 1, 0, 0, 20'ha);
        `CHK(dout, pat(5))
        `CHK(dp, 4'h5)
        `CHK(oe, 1'b1)
        op(0, 1, 0, 3'h1, 20'h0);
        `CHK(dout, pat(10))
        op(0, 1, 0, 3'h1, 20'h0);
        `CHK(oe, 1'b0)
        // A read, then a load with one select inactive: that load must not read
        for (int k = 0; k < 3; k++) begin
            op(0, 1, 0, 0, 20'h5);
            op(0, 1, 0, 3'h1 << k, 20'h6);
            op(0, 1, 0, 3'h1 << k, 20'h0);
            `CHK(oe, 1'b0)
        end
        $display("read test done");
    endtask
    task t_freeze;
        op(0, 1, 0, 0, 20'h3);
        op(1, 1, 0, 0, 20'h7);
        `CHK(ra, 20'h3)
        op(0, 1, 0, 3'h1, 20'h0);
        op(1, 1, 0, 0, 20'h9);
        `CHK(dout, pat(3))
        `CHK(oe, 1'b1)
        $display("freeze test done");
    endtask
    task t_oe;
        @(negedge clk_i) oe_n = 1;
        repeat (6) op(0, 1, 0, 0, 20'h1);
        `CHK(oe, 1'b0)
        @(negedge clk_i) oe_n = 0;
        repeat (6) op(0, 1, 0, 0, 20'h1);
        `CHK(oe, 1'b1)
        $display("enable test done");
    endtask
    // Core stalls, so the third and fourth words find the buffer full
    task t_write;
        @(negedge clk_i);
        stall = 1; bw_n = 4'h5; pin_p = 4'hf;
        for (int i = 0; i < 6; i++) begin
            nd = 32'hc0de0000 + i - 2;
            op(0, 1, i < 4, i < 4 ? 3'h0 : 3'h1, 20'h8 + i);
        end
        `CHK(brdy, 1'b0)
        `CHK({wv, wa, wm, wd, wp}, {1'b1, 20'h8, 4'ha, 32'hc0de0000, 4'hf})
        @(negedge clk_i) stall = 0;
        @(posedge clk_i) #1 `CHK({wv, wa, wd}, {1'b1, 20'h9, 32'hc0de0001})
        @(posedge clk_i) #1 `CHK(wv, 1'b0)
        op(0, 1, 0, 0, 20'h8);
        op(0, 1, 0, 3'h1, 20'h0);
        `CHK({dout, dp}, {32'hc0080008, 4'ha})
        $display("write test done");
    endtask
    task t_burst(input logic o);
        do_reset(o);
        `CHK(ord, o)
        op(0, 1, 0, 0, 20'h12341);
        for (int c = 1; c < 5; c++) begin
            op(0, 0, 0, 0, 20'h0);
            `CHK(ra, {18'h048d0, o ? 2'h1 ^ c[1:0] : 2'h1 + c[1:0]})
        end
        $display("burst test done");
    endtask
    task close_out;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        do_reset(1);
        t_read;
        t_freeze;
        t_oe;
        t_write;
        t_burst(0);
        t_burst(1);
        close_out;
    end
endmodule
bind ssp_port ssp_port_chk ssp_port_chk_inst (.*);
